// [asc_baud_gen.sv]
// Baud divider: counts count-source pulses and gives one oversample tick
// for every setting plus one of them. Assumes one clock and a one-cycle
// source enable from the caller.
`timescale 1ns/100ps
module asc_baud_gen
	import asc_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic src_en,
	input wire logic [DIV_W-1:0] div_value,
	output logic tick
);
	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic tick;
	} asc_bg_state_t;

	asc_bg_state_t state;
	asc_bg_state_t next_state;

	// Reload on zero so the tick rate is source over setting plus one
	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (src_en) begin
			if (state.count == '0) begin
				next_state.count = div_value;
				next_state.tick = 1'b1;
			end else begin
				next_state.count = state.count - 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick = state.tick;
endmodule

// [asc_channel.sv]
// One asynchronous serial channel with its APB register file, transmitter,
// receiver, flow control and shared pin handling.
// Assumes all pin inputs are synchronous to pclk and an APB3 master.
// Summary of operation
// - Mode field 100b/101b/110b picks 7/8/9 bits
// - Buffer bits 0..6, 0..7 or 0..8 hold data
// - Unused upper receive bits read undefined
// - Receive buffer bit 11 reads undefined
// - Receive-only use keeps serial output high
// - Transmit-only frees input pin as port
// - Clock source select picks internal or pin
// - Flow pin is port, CTS or RTS
// - Bit order honoured only for 8 bits
// - Transfers run only while allowed; a transmit frame already started still finishes after the allow bit clears
// - Buffer vacant, shifter vacant, receive complete flags
// - Select bit picks transmit request event
// - Data invert flips character data logic
// - Polarity select flips both serial pins
// - Optional odd/even parity, selectable stop bits
// - Push-pull or open-drain output; channel 2 fixed
// - Shared CTS route feeds channel 0 CTS
// - Count source from divide and clock selects
// - Bit rate is source over sixteen(n+1)
// - Error sum set on any receive error
// - CTS low, allowed and data start transmission
// - Start and stop bits never inverted
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
module asc_channel
	import asc_pkg::*;
#(
	parameter int CHANNEL_INDEX = 0,
	parameter int DIV_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe,
	input wire logic serial_in_pin,
	input wire logic bit_clock_pin_i,
	output logic bit_clock_pin_o,
	output logic bit_clock_pin_oe,
	input wire logic flow_pin_i,
	output logic flow_pin_o,
	output logic flow_pin_oe,
	input wire logic shared_port_pin,
	output logic tx_request,
	output logic rx_request
);
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] ctl0;
		logic [7:0] ctl1;
		logic [DIV_W-1:0] divider;
		logic [31:0] special;
		logic [7:0] shared_ctl;
		logic [4:0] port_ctl;
		logic [8:0] txbuf;
		logic tx_vacant;
		logic tx_busy;
		logic [12:0] tx_shift;
		logic [3:0] tx_bits;
		logic [3:0] tx_tick;
		logic rx_busy;
		logic [3:0] rx_tick;
		logic [3:0] rx_bits;
		logic [3:0] rx_idx;
		logic [11:0] rx_shift;
		logic [8:0] rxbuf;
		logic rx_full;
		logic overrun;
		logic framing;
		logic parity;
		logic [5:0] pre_cnt;
		logic ext_prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic sout;
		logic sout_oe;
		logic clk_o;
		logic clk_oe;
		logic flow_o;
		logic flow_oe;
		logic tx_req;
		logic rx_req;
	} asc_state_t;

	asc_state_t state;
	asc_state_t next_state;
	logic tick;
	logic src_en;

	// Character length from the mode field, zero when not asynchronous
	function automatic logic [3:0] char_len(input logic [2:0] field);
		unique case (field)
			ASC_MODE_CHAR7: char_len = 4'd7;
			ASC_MODE_CHAR8: char_len = 4'd8;
			ASC_MODE_CHAR9: char_len = 4'd9;
			default: char_len = 4'd0;
		endcase
	endfunction

	// Character data as it travels on the line: order and logic applied
	function automatic logic [8:0] line_data(input logic [8:0] d, input logic [3:0] len,
			input logic msb_first, input logic invert);
		logic [8:0] r;
		r = d;
		if (len == 4'd8 && msb_first) begin
			r = {1'b0, d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
		end
		if (invert) begin
			r = ~r;
		end
		if (len == 4'd7) begin
			r[8:7] = 2'h0;
		end else if (len == 4'd8) begin
			r[8] = 1'b0;
		end
		line_data = r;
	endfunction

	// Count source selection for the baud divider
	always_comb begin
		logic [5:0] mask;
		mask = ASC_DIV1_MASK;
		unique case (state.ctl0[ASC_C0_DIV_SOURCE_LSB +: 2])
			2'h1: mask = ASC_DIV8_MASK;
			2'h2, 2'h3: mask = ASC_DIV32_MASK;
			2'h0: mask = ASC_DIV1_MASK;
		endcase
		if (state.shared_ctl[ASC_SH_PCLK_SELECT]) begin
			mask = {mask[4:0], 1'b1};
		end
		if (state.mode[ASC_MODE_CLOCK_SOURCE]) begin
			src_en = bit_clock_pin_i & ~state.ext_prev;
		end else begin
			src_en = (state.pre_cnt & mask) == 6'h00;
		end
	end

	asc_baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.src_en(src_en),
		.div_value(state.divider),
		.tick(tick)
	);

	// Register file, transmitter, receiver and pin logic
	always_comb begin
		logic [3:0] len;
		logic par_on;
		logic two_stop;
		logic pol;
		logic [8:0] ldata;
		logic [8:0] rdata;
		logic line_in;
		logic cts_in;
		logic flow_on;
		logic cts_on;
		logic access;
		logic hit;
		logic [31:0] rd;
		logic ppar;
		logic async;
		next_state = state;
		len = char_len(state.mode[ASC_MODE_FIELD_LSB +: 3]);
		async = len != 4'd0;
		par_on = state.mode[ASC_MODE_PARITY_ENABLE];
		two_stop = state.mode[ASC_MODE_STOP_BITS];
		pol = state.mode[ASC_MODE_PIN_POLARITY];
		line_in = serial_in_pin ^ pol;
		flow_on = ~state.ctl0[ASC_C0_FLOW_DISABLE];
		cts_in = flow_pin_i;
		cts_on = flow_on & ~state.ctl0[ASC_C0_FLOW_SELECT];
		// Channel 0 takes CTS from the shared pin even with RTS selected
		if (CHANNEL_INDEX == 0 && state.shared_ctl[ASC_SH_CTS_ROUTE]) begin
			cts_in = shared_port_pin;
			cts_on = flow_on;
		end
		next_state.pre_cnt = state.pre_cnt + 6'h01;
		next_state.ext_prev = bit_clock_pin_i;
		next_state.tx_req = 1'b0;
		next_state.rx_req = 1'b0;
		ldata = '0;
		rdata = '0;
		ppar = 1'b0;

		// APB slave: answer one cycle into the access phase
		access = psel & penable & ~state.pready;
		next_state.pready = access;
		next_state.pslverr = 1'b0;
		hit = 1'b1;
		rd = 32'h00000000;
		unique case (paddr)
			ASC_OFS_TX_BUFFER: rd = 32'h00000000;
			ASC_OFS_RX_BUFFER: rd = {16'h0000, state.overrun | state.framing | state.parity,
				state.parity, state.framing, state.overrun, 3'h0, state.rxbuf};
			ASC_OFS_BAUD_DIVIDER: rd = 32'h00000000;
			ASC_OFS_SERIAL_MODE: rd = {24'h000000, state.mode};
			ASC_OFS_CONTROL_ZERO: rd = {24'h000000, state.ctl0};
			ASC_OFS_CONTROL_ONE: rd = {24'h000000, state.ctl1};
			ASC_OFS_SPECIAL_A: rd = {24'h000000, state.special[7:0]};
			ASC_OFS_SPECIAL_B: rd = {24'h000000, state.special[15:8]};
			ASC_OFS_SPECIAL_C: rd = {24'h000000, state.special[23:16]};
			ASC_OFS_SPECIAL_D: rd = {24'h000000, state.special[31:24]};
			ASC_OFS_SHARED_CONTROL: rd = {24'h000000, state.shared_ctl};
			ASC_OFS_PORT_CONTROL: rd = {24'h000000, flow_pin_i, bit_clock_pin_i,
				serial_in_pin, state.port_ctl};
			default: hit = 1'b0;
		endcase
		if (access) begin
			next_state.prdata = pwrite ? 32'h00000000 : rd;
			next_state.pslverr = ~hit;
			if (!pwrite && paddr == ASC_OFS_RX_BUFFER) begin
				next_state.rx_full = 1'b0;
			end
		end
		if (psel && penable && state.pready && pwrite) begin
			unique case (paddr)
				ASC_OFS_TX_BUFFER: begin
					next_state.txbuf = pwdata[8:0];
					next_state.tx_vacant = 1'b0;
				end
				ASC_OFS_BAUD_DIVIDER: next_state.divider = pwdata[DIV_W-1:0];
				ASC_OFS_SERIAL_MODE: next_state.mode = pwdata[7:0];
				ASC_OFS_CONTROL_ZERO: begin
					next_state.ctl0 = {pwdata[7:4], state.ctl0[ASC_C0_SHIFT_VACANT], pwdata[2:0]};
					if (CHANNEL_INDEX == 2) begin
						next_state.ctl0[ASC_C0_OPEN_DRAIN] = 1'b0;
					end
				end
				ASC_OFS_CONTROL_ONE: begin
					next_state.ctl1 = {pwdata[7:4], state.ctl1[ASC_C1_RX_COMPLETE],
						pwdata[2], state.ctl1[ASC_C1_TX_VACANT], pwdata[0]};
				end
				ASC_OFS_SPECIAL_A: next_state.special[7:0] = pwdata[7:0];
				ASC_OFS_SPECIAL_B: next_state.special[15:8] = pwdata[7:0];
				ASC_OFS_SPECIAL_C: next_state.special[23:16] = pwdata[7:0];
				ASC_OFS_SPECIAL_D: next_state.special[31:24] = pwdata[7:0];
				ASC_OFS_SHARED_CONTROL: next_state.shared_ctl = pwdata[7:0];
				ASC_OFS_PORT_CONTROL: next_state.port_ctl = pwdata[4:0];
				default: next_state.pslverr = 1'b0;
			endcase
		end

		// Transmitter: load from the buffer, then shift one bit per 16 ticks
		if (!async) begin
			next_state.tx_busy = 1'b0;
			next_state.tx_vacant = 1'b1;
		end else if (tick) begin
			if (state.tx_busy) begin
				next_state.tx_tick = state.tx_tick + 4'h1;
				if (state.tx_tick == ASC_TICK_LAST) begin
					next_state.tx_shift = {1'b1, state.tx_shift[12:1]};
					next_state.tx_bits = state.tx_bits - 4'h1;
					if (state.tx_bits == 4'h1) begin
						next_state.tx_busy = 1'b0;
						next_state.tx_req = state.ctl1[ASC_C1_TX_IRQ_SOURCE];
					end
				end
			end else if (state.ctl1[ASC_C1_TX_ALLOW] && !state.tx_vacant
					&& (!cts_on || !cts_in)) begin
				ldata = line_data(state.txbuf, len, state.ctl0[ASC_C0_BIT_ORDER],
					state.ctl1[ASC_C1_DATA_INVERT]);
				ppar = ^ldata ^ ~state.mode[ASC_MODE_ODD_EVEN];
				next_state.tx_shift = ({4'hf, ldata} << 1) | 13'h1e00;
				next_state.tx_shift[4'd1 + len] = par_on ? ppar : 1'b1;
				for (int i = 0; i < 10; i++) begin
					if (i >= len + 1 && i >= 1) begin
						next_state.tx_shift[i] = (i == len + 1 && par_on) ? ppar : 1'b1;
					end
				end
				next_state.tx_bits = 4'd2 + len + {3'h0, par_on} + {3'h0, two_stop};
				next_state.tx_tick = 4'h0;
				next_state.tx_busy = 1'b1;
				next_state.tx_vacant = 1'b1;
				next_state.tx_req = ~state.ctl1[ASC_C1_TX_IRQ_SOURCE];
			end
		end
		next_state.ctl1[ASC_C1_TX_VACANT] = next_state.tx_vacant;
		next_state.ctl0[ASC_C0_SHIFT_VACANT] = ~next_state.tx_busy;

		// Receiver: start on a low level, sample mid-bit every 16 ticks
		if (!async || !state.ctl1[ASC_C1_RX_ALLOW]) begin
			next_state.rx_busy = 1'b0;
			if (!state.ctl1[ASC_C1_RX_ALLOW]) begin
				next_state.rx_full = 1'b0;
				next_state.overrun = 1'b0;
				next_state.framing = 1'b0;
				next_state.parity = 1'b0;
			end
		end else if (tick) begin
			if (!state.rx_busy) begin
				if (!line_in) begin
					next_state.rx_busy = 1'b1;
					next_state.rx_tick = 4'h0;
					next_state.rx_idx = 4'h0;
					next_state.rx_bits = len + {3'h0, par_on} + {3'h0, two_stop} + 4'h2;
				end
			end else begin
				next_state.rx_tick = state.rx_tick + 4'h1;
				if (state.rx_tick == ASC_TICK_MID) begin
					if (state.rx_idx == 4'h0 && line_in) begin
						next_state.rx_busy = 1'b0;
					end else if (state.rx_idx != 4'h0) begin
						next_state.rx_shift[state.rx_idx - 4'h1] = line_in;
					end
					next_state.rx_idx = state.rx_idx + 4'h1;
					if (state.rx_idx == state.rx_bits - 4'h1) begin
						rdata = state.rx_shift[8:0];
						rdata = line_data(rdata & ~(9'h1ff << len), len,
							state.ctl0[ASC_C0_BIT_ORDER], state.ctl1[ASC_C1_DATA_INVERT]);
						next_state.rxbuf = rdata;
						next_state.parity = par_on && ((^(state.rx_shift[8:0] & ~(9'h1ff << len)))
							^ state.rx_shift[len] ^ ~state.mode[ASC_MODE_ODD_EVEN]);
						next_state.framing = !line_in || (two_stop && !par_on ?
							!state.rx_shift[len] : (two_stop && !state.rx_shift[len + 4'h1]));
						next_state.overrun = state.rx_full;
						next_state.rx_full = 1'b1;
						next_state.rx_req = 1'b1;
						next_state.rx_busy = 1'b0;
					end
				end
			end
		end
		next_state.ctl1[ASC_C1_RX_COMPLETE] = next_state.rx_full;

		// Serial output pin: idle high, polarity and output mode applied
		next_state.sout = (state.tx_busy ? state.tx_shift[0] : 1'b1) ^ pol;
		if (CHANNEL_INDEX == 2 || state.ctl0[ASC_C0_OPEN_DRAIN]) begin
			next_state.sout_oe = async & ~next_state.sout;
			next_state.sout = 1'b0;
		end else begin
			next_state.sout_oe = async;
		end

		// Clock pin: general port with internal clock, input otherwise
		next_state.clk_o = state.port_ctl[ASC_PC_CLK_OUT];
		next_state.clk_oe = ~state.mode[ASC_MODE_CLOCK_SOURCE]
			& state.port_ctl[ASC_PC_CLK_DIR];

		// Flow pin: port, CTS input or RTS output ready when reception is allowed and the buffer is empty
		if (!flow_on) begin
			next_state.flow_o = state.port_ctl[ASC_PC_FLOW_OUT];
			next_state.flow_oe = state.port_ctl[ASC_PC_FLOW_DIR];
		end else if (state.ctl0[ASC_C0_FLOW_SELECT]) begin
			next_state.flow_o = ~(state.ctl1[ASC_C1_RX_ALLOW] & ~state.rx_full);
			next_state.flow_oe = 1'b1;
		end else begin
			next_state.flow_o = 1'b0;
			next_state.flow_oe = 1'b0;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
			state.ctl0 <= ASC_RST_CONTROL_ZERO;
			state.ctl1 <= ASC_RST_CONTROL_ONE;
			state.mode <= ASC_RST_BYTE;
			state.tx_vacant <= 1'b1;
			state.tx_shift <= 13'h1fff;
			state.sout <= 1'b1;
			state.flow_o <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign serial_out_pin_o = state.sout;
	assign serial_out_pin_oe = state.sout_oe;
	assign bit_clock_pin_o = state.clk_o;
	assign bit_clock_pin_oe = state.clk_oe;
	assign flow_pin_o = state.flow_o;
	assign flow_pin_oe = state.flow_oe;
	assign tx_request = state.tx_req;
	assign rx_request = state.rx_req;
endmodule

// [asc_checker.sv]
// Checker for the serial channel: bus answer, flags and pin levels.
// Assumes it is bound to asc_channel and sees only its ports.
`timescale 1ns/100ps
module asc_checker
	import asc_pkg::*;
#(
	parameter int CHANNEL_INDEX = 0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe,
	input wire logic flow_pin_i,
	input wire logic flow_pin_oe,
	input wire logic tx_request
);
	logic [7:0] mode, c0, c1;
	logic line, rd_rx, async_md, rx_only, rts_cfg, cts_cfg, od_cfg, pol;
	// Line level with the pull-up seen when the pin is released
	assign line = serial_out_pin_oe ? serial_out_pin_o : 1'b1;
	assign rd_rx = pready && !pwrite && paddr == ASC_OFS_RX_BUFFER;
	assign async_md = mode[2:0] inside {ASC_MODE_CHAR7, ASC_MODE_CHAR8, ASC_MODE_CHAR9};
	assign pol = mode[ASC_MODE_PIN_POLARITY];
	assign rx_only = async_md && !c1[ASC_C1_TX_ALLOW] && !pol;
	assign rts_cfg = !c0[ASC_C0_FLOW_DISABLE] && c0[ASC_C0_FLOW_SELECT];
	assign cts_cfg = !c0[ASC_C0_FLOW_DISABLE] && !c0[ASC_C0_FLOW_SELECT];
	assign od_cfg = c0[ASC_C0_OPEN_DRAIN] || CHANNEL_INDEX == 2;
	// Shadow copies of the configuration written over the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= ASC_RST_BYTE;
			c0 <= ASC_RST_CONTROL_ZERO;
			c1 <= ASC_RST_CONTROL_ONE;
		end else if (psel && penable && pready && pwrite) begin
			if (paddr == ASC_OFS_SERIAL_MODE) mode <= pwdata[7:0];
			if (paddr == ASC_OFS_CONTROL_ZERO) c0 <= pwdata[7:0];
			if (paddr == ASC_OFS_CONTROL_ONE) c1 <= pwdata[7:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence apb_done;
		psel && penable && !pready ##1 psel && penable && pready;
	endsequence
	AST_APB_ANSWER:
		assert property (apb_setup |=> apb_done) else $error("late bus answer");
	AST_UNMAPPED:
		assert property (pready && !pwrite && paddr > ASC_OFS_PORT_CONTROL |-> pslverr
			&& prdata == 32'h0) else $error("unmapped read not refused");
	AST_ERR_SUM:
		assert property (rd_rx |-> prdata[15] == |prdata[14:12]) else $error("error sum");
	AST_RX_UNUSED:
		assert property (rd_rx |-> !prdata[11] && (mode[2:0] != ASC_MODE_CHAR7
			|| prdata[8:7] == 2'b00) && (mode[2:0] != ASC_MODE_CHAR8 || !prdata[8]))
			else $error("unused receive bits set");
	AST_RX_ONLY_HIGH:
		assert property (rx_only [*3] |-> line) else $error("output low in receive only");
	AST_TX_ALLOW:
		assert property ($fell(line) && !pol |-> c1[ASC_C1_TX_ALLOW])
			else $error("sent without allow");
	AST_CTS_HOLD:
		assert property (cts_cfg && !c1[ASC_C1_TX_IRQ_SOURCE] && flow_pin_i && $past(flow_pin_i)
			&& $past(flow_pin_i, 2) && $past(flow_pin_i, 3) |-> !tx_request)
			else $error("load while clear-to-send high");
	AST_RTS_OUT:
		assert property (rts_cfg [*3] |-> flow_pin_oe) else $error("flow pin not driven");
	AST_OPEN_DRAIN:
		assert property (od_cfg [*3] ##0 serial_out_pin_oe |-> !serial_out_pin_o)
			else $error("open drain drives high");
	AST_LOAD_START:
		assert property (tx_request && !c1[ASC_C1_TX_IRQ_SOURCE] && !pol |-> ##[0:3] !line)
			else $error("load request without start bit");
	AST_END_IDLE:
		assert property (tx_request && c1[ASC_C1_TX_IRQ_SOURCE] && !pol |-> line)
			else $error("end request before frame end");
endmodule

bind asc_channel asc_checker #(.CHANNEL_INDEX(CHANNEL_INDEX)) asc_checker_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.serial_out_pin_o(serial_out_pin_o),
	.serial_out_pin_oe(serial_out_pin_oe),
	.flow_pin_i(flow_pin_i),
	.flow_pin_oe(flow_pin_oe),
	.tx_request(tx_request)
);

// [asc_peer.sv]
// Remote asynchronous transceiver model.
// Assumes a bit time of BIT clock cycles and an idle-high line.
`timescale 1ns/100ps
module asc_peer #(
	parameter int BIT = 32
) (
	input wire logic pclk,
	input wire logic rx_line,
	output logic tx_line
);
	initial tx_line = 1'b1;
	// Start bit, then n frame bits from bit 0 up, then idle high
	task automatic send(input logic [11:0] bits, input int n);
		int i;
		logic [12:0] f;
		f = {bits, 1'b0};
		for (i = 0; i <= n; i++) begin
			tx_line <= f[i];
			repeat (BIT) @(posedge pclk);
		end
		tx_line <= 1'b1;
	endtask
	// Wait for a start bit, then sample n bits at their centres
	task automatic capture(input int n, output logic [11:0] bits);
		int i;
		bits = '0;
		while (rx_line !== 1'b0) @(posedge pclk);
		repeat (BIT / 2) @(posedge pclk);
		for (i = 0; i < n; i++) begin
			repeat (BIT) @(posedge pclk);
			bits[i] = rx_line;
		end
	endtask
endmodule

// [asc_pkg.sv]
// Package for the asynchronous serial channel: register map, field
// positions, reset values and encodings shared by the channel and its divider.
// Assumes a 32-bit APB register bus with each register in one aligned word.
package asc_pkg;
	// Register byte offsets
	localparam logic [7:0] ASC_OFS_TX_BUFFER = 8'h00;
	localparam logic [7:0] ASC_OFS_RX_BUFFER = 8'h04;
	localparam logic [7:0] ASC_OFS_BAUD_DIVIDER = 8'h08;
	localparam logic [7:0] ASC_OFS_SERIAL_MODE = 8'h0c;
	localparam logic [7:0] ASC_OFS_CONTROL_ZERO = 8'h10;
	localparam logic [7:0] ASC_OFS_CONTROL_ONE = 8'h14;
	localparam logic [7:0] ASC_OFS_SPECIAL_A = 8'h18;
	localparam logic [7:0] ASC_OFS_SPECIAL_B = 8'h1c;
	localparam logic [7:0] ASC_OFS_SPECIAL_C = 8'h20;
	localparam logic [7:0] ASC_OFS_SPECIAL_D = 8'h24;
	localparam logic [7:0] ASC_OFS_SHARED_CONTROL = 8'h28;
	localparam logic [7:0] ASC_OFS_PORT_CONTROL = 8'h2c;

	// Serial mode register fields
	localparam int ASC_MODE_FIELD_LSB = 0;
	localparam int ASC_MODE_CLOCK_SOURCE = 3;
	localparam int ASC_MODE_STOP_BITS = 4;
	localparam int ASC_MODE_ODD_EVEN = 5;
	localparam int ASC_MODE_PARITY_ENABLE = 6;
	localparam int ASC_MODE_PIN_POLARITY = 7;
	localparam logic [2:0] ASC_MODE_CHAR7 = 3'h4;
	localparam logic [2:0] ASC_MODE_CHAR8 = 3'h5;
	localparam logic [2:0] ASC_MODE_CHAR9 = 3'h6;

	// Control zero register fields
	localparam int ASC_C0_DIV_SOURCE_LSB = 0;
	localparam int ASC_C0_FLOW_SELECT = 2;
	localparam int ASC_C0_SHIFT_VACANT = 3;
	localparam int ASC_C0_FLOW_DISABLE = 4;
	localparam int ASC_C0_OPEN_DRAIN = 5;
	localparam int ASC_C0_CLOCK_EDGE = 6;
	localparam int ASC_C0_BIT_ORDER = 7;

	// Control one register fields
	localparam int ASC_C1_TX_ALLOW = 0;
	localparam int ASC_C1_TX_VACANT = 1;
	localparam int ASC_C1_RX_ALLOW = 2;
	localparam int ASC_C1_RX_COMPLETE = 3;
	localparam int ASC_C1_TX_IRQ_SOURCE = 4;
	localparam int ASC_C1_CONT_RX = 5;
	localparam int ASC_C1_DATA_INVERT = 6;
	localparam int ASC_C1_ERROR_SIGNAL = 7;

	// Shared control register fields
	localparam int ASC_SH_CLOCK_MULTI = 5;
	localparam int ASC_SH_CTS_ROUTE = 6;
	localparam int ASC_SH_PCLK_SELECT = 7;

	// Port control register fields (general port use of shared pins)
	localparam int ASC_PC_CLK_OUT = 0;
	localparam int ASC_PC_CLK_DIR = 1;
	localparam int ASC_PC_FLOW_OUT = 2;
	localparam int ASC_PC_FLOW_DIR = 3;
	localparam int ASC_PC_SIN_DIR = 4;
	localparam int ASC_PC_SIN_LEVEL = 5;
	localparam int ASC_PC_CLK_LEVEL = 6;
	localparam int ASC_PC_FLOW_LEVEL = 7;

	// Receive buffer flag positions
	localparam int ASC_RB_OVERRUN = 12;
	localparam int ASC_RB_FRAMING = 13;
	localparam int ASC_RB_PARITY = 14;
	localparam int ASC_RB_ERROR_SUM = 15;

	// Reset values
	localparam logic [7:0] ASC_RST_BYTE = 8'h00;
	localparam logic [7:0] ASC_RST_CONTROL_ZERO = 8'h08;
	localparam logic [7:0] ASC_RST_CONTROL_ONE = 8'h02;

	// Timing: oversample ticks per bit and the mid-bit sample point
	localparam logic [3:0] ASC_TICK_LAST = 4'hf;
	localparam logic [3:0] ASC_TICK_MID = 4'h7;

	// Prescaler divide masks for the count source
	localparam logic [5:0] ASC_DIV1_MASK = 6'h00;
	localparam logic [5:0] ASC_DIV8_MASK = 6'h07;
	localparam logic [5:0] ASC_DIV32_MASK = 6'h1f;
endpackage

// [testbench.sv]
// Self-checking bench for the serial channel over APB.
// Assumes the count source is pclk, so a bit lasts 16 (divider + 1) cycles.
`timescale 1ns/100ps
module testbench
	import asc_pkg::*;
;
	localparam int DIVN = 1;
	localparam int BIT = 16 * (DIVN + 1);
	localparam logic [7:0] tx_mode [5] = '{8'h05, 8'h05, 8'h64, 8'h56, 8'h05};
	localparam logic [7:0] tx_c0 [5] = '{8'h08, 8'h80, 8'h00, 8'h20, 8'h00};
	localparam logic [7:0] tx_c1 [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h51};
	localparam logic [8:0] tx_dat [5] = '{9'h0a5, 9'h035, 9'h0d3, 9'h12b, 9'h00f};
	localparam int tx_n [5] = '{9, 9, 9, 12, 9};
	localparam logic [11:0] tx_exp [5] = '{12'h1a5, 12'h1ac, 12'h153, 12'hd2b, 12'h1f0};
	localparam logic [7:0] rx_mode [4] = '{8'h05, 8'h04, 8'h05, 8'h65};
	localparam logic [11:0] rx_bits [4] = '{12'h15a, 12'h0ff, 12'h081, 12'h201};
	localparam int rx_n [4] = '{9, 8, 9, 10};
	localparam logic [31:0] rx_exp [4] = '{32'h5a, 32'h7f, 32'ha081, 32'hc001};
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic tx_o, tx_oe, rx_in, clk_i, clk_o, clk_oe, flow_i, flow_o, flow_oe, sh_pin;
	logic tx_req, rx_req, line;
	logic [11:0] got;
	int n_fail = 0;
	int checks_done = 0;
	int n_tx_req = 0;
	int n_rx_req = 0;
	// Count request pulses, each stands one cycle
	always @(posedge pclk) begin
		if (tx_req === 1'b1) n_tx_req++;
		if (rx_req === 1'b1) n_rx_req++;
	end
	// Clock and the output wire with its pull-up
	always #2 pclk = ~pclk;
	assign line = tx_oe ? tx_o : 1'b1;
	asc_channel asc_channel_i (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.serial_out_pin_o(tx_o),
		.serial_out_pin_oe(tx_oe),
		.serial_in_pin(rx_in),
		.bit_clock_pin_i(clk_i),
		.bit_clock_pin_o(clk_o),
		.bit_clock_pin_oe(clk_oe),
		.flow_pin_i(flow_i),
		.flow_pin_o(flow_o),
		.flow_pin_oe(flow_oe),
		.shared_port_pin(sh_pin),
		.tx_request(tx_req),
		.rx_request(rx_req)
	);
	asc_peer #(.BIT(BIT)) asc_peer_i (.pclk(pclk), .rx_line(line), .tx_line(rx_in));
	task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
		checks_done++;
		if (got_v !== exp_v) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask
	// One APB transfer: setup, access until ready, release, one idle edge
	task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int w;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, is_wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		w = 0;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'b1 && w < 50);
		q = prdata;
		e = pslverr;
		chk(32'(pready), 32'h1);
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp_v, input logic err);
		logic [31:0] q;
		logic e;
		xfer(1'b0, a, 32'h0, q, e);
		chk(q, exp_v);
		chk(32'(e), 32'(err));
	endtask
	task automatic report_and_stop();
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		int k;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{presetn, clk_i, flow_i, sh_pin} = 4'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ASC_OFS_CONTROL_ZERO, 32'(ASC_RST_CONTROL_ZERO), 1'b0);
		rd(ASC_OFS_CONTROL_ONE, 32'(ASC_RST_CONTROL_ONE), 1'b0);
		rd(ASC_OFS_TX_BUFFER, 32'h0, 1'b0);
		rd(8'h30, 32'h0, 1'b1);
		wr(ASC_OFS_PORT_CONTROL, 32'h03);
		rd(ASC_OFS_PORT_CONTROL, 32'h23, 1'b0);
		chk(32'({clk_oe, clk_o}), 32'h3);
		wr(ASC_OFS_BAUD_DIVIDER, 32'(DIVN));
		// Frame formats, bit order, parity, inversion and output modes
		for (k = 0; k < 5; k++) begin
			wr(ASC_OFS_SERIAL_MODE, 32'(tx_mode[k]));
			wr(ASC_OFS_CONTROL_ZERO, 32'(tx_c0[k]));
			wr(ASC_OFS_CONTROL_ONE, 32'(tx_c1[k]));
			wr(ASC_OFS_TX_BUFFER, 32'(tx_dat[k]));
			asc_peer_i.capture(tx_n[k], got);
			chk(32'(got), 32'(tx_exp[k]));
			repeat (BIT * 2) @(posedge pclk);
		end
		// Transmission waits while clear-to-send is high
		wr(ASC_OFS_CONTROL_ONE, 32'h01);
		flow_i <= 1'b1;
		wr(ASC_OFS_TX_BUFFER, 32'h3c);
		repeat (BIT * 4) @(posedge pclk);
		rd(ASC_OFS_CONTROL_ONE, 32'h01, 1'b0);
		flow_i <= 1'b0;
		asc_peer_i.capture(9, got);
		chk(32'(got), 32'h13c);
		repeat (BIT) @(posedge pclk);
		rd(ASC_OFS_CONTROL_ONE, 32'h03, 1'b0);
		rd(ASC_OFS_CONTROL_ZERO, 32'h08, 1'b0);
		// Shared pin carries clear-to-send for channel 0 with RTS selected
		wr(ASC_OFS_SHARED_CONTROL, 32'h40);
		wr(ASC_OFS_CONTROL_ZERO, 32'h04);
		sh_pin <= 1'b1;
		wr(ASC_OFS_TX_BUFFER, 32'h5a);
		repeat (BIT * 4) @(posedge pclk);
		rd(ASC_OFS_CONTROL_ONE, 32'h01, 1'b0);
		sh_pin <= 1'b0;
		asc_peer_i.capture(9, got);
		chk(32'(got), 32'h15a);
		repeat (BIT) @(posedge pclk);
		// Reception with request-to-send, then framing and parity faults
		wr(ASC_OFS_CONTROL_ZERO, 32'h04);
		wr(ASC_OFS_CONTROL_ONE, 32'h04);
		repeat (3) @(posedge pclk);
		chk(32'({flow_oe, flow_o}), 32'h2);
		for (k = 0; k < 4; k++) begin
			wr(ASC_OFS_SERIAL_MODE, 32'(rx_mode[k]));
			asc_peer_i.send(rx_bits[k], rx_n[k]);
			repeat (BIT) @(posedge pclk);
			rd(ASC_OFS_CONTROL_ONE, 32'h0e, 1'b0);
			rd(ASC_OFS_RX_BUFFER, rx_exp[k], 1'b0);
			rd(ASC_OFS_CONTROL_ONE, 32'h06, 1'b0);
		end
		chk(32'(n_tx_req), 32'h7);
		chk(32'(n_rx_req), 32'h4);
		// Polarity flips the idle level of the output
		wr(ASC_OFS_SERIAL_MODE, 32'h85);
		repeat (3) @(posedge pclk);
		chk(32'(line), 32'h0);
		wr(ASC_OFS_SERIAL_MODE, 32'h05);
		repeat (3) @(posedge pclk);
		chk(32'(line), 32'h1);
		report_and_stop();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (30000) @(posedge pclk);
		n_fail++;
		report_and_stop();
	end
endmodule
